// ### hw/rsw_consts.svh
// constants for the reset, strap latch and wake pin block
`ifndef RSW_CONSTS_SVH
`define RSW_CONSTS_SVH
`define RSW_CLK_PERIOD_NS   8
`define RSW_POR_TIME_NS     2000
`define RSW_CMD_RST_TIME_NS 1000
`define RSW_OFS_CTRL        8'h00
`define RSW_OFS_IRQ_CFG     8'h04
`define RSW_OFS_WAKE_CFG    8'h08
`define RSW_OFS_STATUS      8'h0c
`define RSW_OFS_MASK        8'h10
`define RSW_OFS_STRAP       8'h14
`define RSW_CTRL_RST_BIT    0
`define RSW_CTRL_WCLR_BIT   1
`define RSW_IRQ_POL_BIT     0
`define RSW_IRQ_OD_BIT      1
`define RSW_WAKE_EN_BIT     0
`define RSW_WAKE_POL_BIT    1
`define RSW_WAKE_OD_BIT     2
`define RSW_WAKE_SEL_LSB    4
`define RSW_ST_LATCH_BIT    0
`define RSW_ST_CMDRST_BIT   1
`define RSW_ST_WAKE_BIT     2
`define RSW_ST_EXT_BIT      3
`define RSW_STRAP_LVL_LSB   8
`define RSW_STRAP_VALID_BIT 12
`define RSW_IRQ_CFG_RST     2'h0
`define RSW_WAKE_CFG_RST    6'h00
`define RSW_MASK_RST        4'h0
`endif

// ### hw/rsw_pkg.sv
// types shared by the reset, strap latch and wake pin block
package rsw_pkg;
   typedef enum logic [2:0] {
      ST_POR = 3'b001,
      ST_CMD = 3'b010,
      ST_RUN = 3'b100
   } seq_state_t;
   typedef enum logic [1:0] {
      LVL_LOW  = 2'b00,
      LVL_MID  = 2'b01,
      LVL_HIGH = 2'b11
   } clk_level_t;
endpackage

// ### hw/reset_strap_wake_pins.sv
// reset sequencing, strap latching, interrupt and wake pins with an avalon-mm register slave
`timescale 1ns/10ps
`include "rsw_consts.svh"

module reset_strap_wake_pins
   import rsw_pkg::*;
#(
   parameter int STRAP_W        = 4,
   parameter int POR_CYCLES     = (`RSW_POR_TIME_NS + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS,
   parameter int CMD_RST_CYCLES = (`RSW_CMD_RST_TIME_NS + `RSW_CLK_PERIOD_NS - 1)
                                  / `RSW_CLK_PERIOD_NS
) (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic [7:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic               rst_pin_n_in,
   output logic                    rst_pin_out,
   output logic                    rst_pin_oe,
   input  wire logic               net_reset_cmd,
   input  wire logic [STRAP_W-1:0] strap_in,
   input  wire logic [1:0]         osc_input_mode_strap,
   input  wire logic               wake_detect,
   input  wire logic               eeprom_load_fail,
   input  wire logic               err_led_req,
   input  wire logic               irq_src,
   output logic                    core_reset,
   output logic [STRAP_W-1:0]      straps_latched,
   output logic                    straps_valid,
   output logic                    ref_clk_out_en,
   output logic                    osc_in_schmitt,
   output logic                    irq_out,
   output logic                    irq_oe,
   output logic                    error_indicator_pin,
   output logic                    error_indicator_oe,
   output logic [2:0]              wake_event_out,
   output logic [2:0]              wake_event_oe
);

   // drive for a pin of programmable polarity and drive type: {out, oe}
   function automatic logic [1:0] pin_drive(input logic act, input logic pol,
                                            input logic od);
      logic lvl;
      lvl = act ~^ pol;
      pin_drive = od ? {1'b0, ~lvl} : {lvl, 1'b1};
   endfunction

   localparam int CNT_W = $clog2(POR_CYCLES + CMD_RST_CYCLES + 1);

   seq_state_t         state_r;
   seq_state_t         state_nxt;
   logic [CNT_W-1:0]   cnt_r;
   logic [CNT_W-1:0]   cnt_nxt;
   logic               pin_d_r;
   logic [1:0]         irq_cfg_r;
   logic [5:0]         wake_cfg_r;
   logic [3:0]         status_r;
   logic [3:0]         status_nxt;
   logic [3:0]         mask_r;
   logic               wake_pend_r;
   logic               wait_r;
   logic [31:0]        rdata_r;
   logic [STRAP_W-1:0] straps_r;
   logic [1:0]         lvl_r;
   logic               valid_r;
   logic               clk_en_r;
   logic               schmitt_r;

   // bus decode
   wire        req        = avs_read | avs_write;
   wire        accept     = req & wait_r;
   wire        done       = req & ~wait_r;
   wire        wr_done    = done & avs_write & avs_byteenable[0];
   wire        sel_ctrl   = avs_address == `RSW_OFS_CTRL;
   wire        sel_irq    = avs_address == `RSW_OFS_IRQ_CFG;
   wire        sel_wake   = avs_address == `RSW_OFS_WAKE_CFG;
   wire        sel_status = avs_address == `RSW_OFS_STATUS;
   wire        sel_mask   = avs_address == `RSW_OFS_MASK;
   wire        sel_strap  = avs_address == `RSW_OFS_STRAP;
   wire        host_rst   = wr_done & sel_ctrl & avs_writedata[`RSW_CTRL_RST_BIT];
   wire        wake_clr   = wr_done & sel_ctrl & avs_writedata[`RSW_CTRL_WCLR_BIT];
   wire [31:0] strap_word = {19'h0, valid_r, 2'h0, lvl_r, {(8-STRAP_W){1'b0}}, straps_r};
   wire [31:0] rd_mux     = sel_irq    ? {30'h0, irq_cfg_r}  :
                            sel_wake   ? {26'h0, wake_cfg_r} :
                            sel_status ? {28'h0, status_r}   :
                            sel_mask   ? {28'h0, mask_r}     :
                            sel_strap  ? strap_word          : 32'h0;

   // config fields
   wire       irq_pol  = irq_cfg_r[`RSW_IRQ_POL_BIT];
   wire       irq_od   = irq_cfg_r[`RSW_IRQ_OD_BIT];
   wire       wake_en  = wake_cfg_r[`RSW_WAKE_EN_BIT];
   wire       wake_pol = wake_cfg_r[`RSW_WAKE_POL_BIT];
   wire       wake_od  = wake_cfg_r[`RSW_WAKE_OD_BIT];
   wire [1:0] wake_sel = wake_cfg_r[`RSW_WAKE_SEL_LSB +: 2];

   // reset sequencing
   wire cmd_req   = net_reset_cmd | host_rst;
   wire pin_rise  = rst_pin_n_in & ~pin_d_r;
   wire seq_end   = (state_r != ST_RUN) & (state_nxt == ST_RUN);
   wire latch_evt = seq_end | pin_rise;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_POR: begin
            if (cnt_r == '0) begin
               state_nxt = ST_RUN;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         ST_CMD: begin
            if (cnt_r == '0) begin
               state_nxt = ST_RUN;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         ST_RUN: begin
            if (cmd_req) begin
               state_nxt = ST_CMD;
               cnt_nxt   = CNT_W'(CMD_RST_CYCLES - 1);
            end
         end
         default: begin
            state_nxt = ST_POR;
            cnt_nxt   = CNT_W'(POR_CYCLES - 1);
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= ST_POR;
         cnt_r   <= CNT_W'(POR_CYCLES - 1);
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // the pin is open drain: only ever pulled low, released otherwise
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_d_r     <= 1'b0;
         rst_pin_out <= 1'b0;
         rst_pin_oe  <= 1'b1;
         core_reset  <= 1'b1;
      end else begin
         pin_d_r     <= rst_pin_n_in;
         rst_pin_out <= 1'b0;
         rst_pin_oe  <= state_nxt != ST_RUN;
         core_reset  <= (state_nxt != ST_RUN) | ~rst_pin_n_in;
      end
   end

   // strap capture; a floating three-level strap reads as middle in the comparator
   always_ff @(posedge clk) begin
      if (srst) begin
         straps_r  <= '0;
         lvl_r     <= 2'h0;
         valid_r   <= 1'b0;
         clk_en_r  <= 1'b0;
         schmitt_r <= 1'b0;
      end else if (latch_evt) begin
         straps_r  <= strap_in;
         lvl_r     <= osc_input_mode_strap;
         valid_r   <= 1'b1;
         clk_en_r  <= osc_input_mode_strap != LVL_LOW;
         schmitt_r <= osc_input_mode_strap == LVL_HIGH;
      end
   end

   assign straps_latched = straps_r;
   assign straps_valid   = valid_r;
   assign ref_clk_out_en = clk_en_r;
   assign osc_in_schmitt = schmitt_r;

   // sticky events; only bits already reported by the read are cleared, and a set wins
   assign status_nxt = (status_r & ~((done & avs_read & sel_status) ? rdata_r[3:0] : 4'h0))
                       | {irq_src, wake_en & wake_detect, seq_end & (state_r == ST_CMD),
                          latch_evt};

   always_ff @(posedge clk) begin
      if (srst) begin
         wait_r     <= 1'b1;
         rdata_r    <= 32'h0;
         irq_cfg_r  <= `RSW_IRQ_CFG_RST;
         wake_cfg_r <= `RSW_WAKE_CFG_RST;
         mask_r     <= `RSW_MASK_RST;
         status_r   <= 4'h0;
      end else begin
         wait_r   <= ~accept;
         rdata_r  <= accept ? rd_mux : rdata_r;
         status_r <= status_nxt;
         if (wr_done & sel_irq) begin
            irq_cfg_r <= avs_writedata[1:0];
         end
         if (wr_done & sel_wake) begin
            wake_cfg_r <= avs_writedata[5:0];
         end
         if (wr_done & sel_mask) begin
            mask_r <= avs_writedata[3:0];
         end
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;

   // wake pending holds until software clears it or wake_en drops; a new event in the same cycle wins
   always_ff @(posedge clk) begin
      if (srst) begin
         wake_pend_r <= 1'b0;
      end else begin
         wake_pend_r <= (wake_pend_r & ~wake_clr & wake_en) | (wake_en & wake_detect);
      end
   end

   // pin drivers, all registered
   wire [1:0] irq_drv   = pin_drive(|(status_nxt & mask_r), irq_pol, irq_od);
   wire [1:0] wake_drv  = pin_drive(wake_pend_r, wake_pol, wake_od);
   wire       on_err    = wake_en & (wake_sel == 2'd0);
   // forcing the error function means a wake listener there may see false events
   wire       err_force = on_err & eeprom_load_fail;

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_out             <= 1'b0;
         irq_oe              <= 1'b0;
         error_indicator_pin <= 1'b0;
         error_indicator_oe  <= 1'b1;
         wake_event_out      <= 3'h0;
         wake_event_oe       <= 3'h0;
      end else begin
         irq_out <= irq_drv[1];
         irq_oe  <= irq_drv[0];
         if (on_err & ~err_force) begin
            error_indicator_pin <= wake_drv[1];
            error_indicator_oe  <= wake_drv[0];
         end else begin
            error_indicator_pin <= err_led_req;
            error_indicator_oe  <= 1'b1;
         end
         for (int i = 0; i < 3; i++) begin
            wake_event_out[i] <= (wake_en & (wake_sel == 2'(i + 1))) & wake_drv[1];
            wake_event_oe[i]  <= (wake_en & (wake_sel == 2'(i + 1))) & wake_drv[0];
         end
      end
   end

   AST_POR_AFTER_SRST: assert property (@(posedge clk) srst |=> (core_reset && rst_pin_oe) [*2])
      else $error("power-on reset did not start after srst");
   AST_PIN_HOLDS_RESET: assert property (@(posedge clk) disable iff (srst)
      !rst_pin_n_in |=> core_reset)
      else $error("reset pin low but core not in reset");
   AST_CMD_PULLS_PIN: assert property (@(posedge clk) disable iff (srst)
      (net_reset_cmd && state_r == ST_RUN) |=> rst_pin_oe && !rst_pin_out ##1 rst_pin_oe)
      else $error("reset command did not pull the reset pin");
   AST_STRAP_CAPTURE: assert property (@(posedge clk) disable iff (srst)
      latch_evt |=> straps_latched == $past(strap_in) && straps_valid)
      else $error("straps not captured at latch event");
   AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (srst)
      !latch_evt |=> $stable(straps_latched) && $stable(ref_clk_out_en) && $stable(osc_in_schmitt))
      else $error("strap selections changed without a latch event");
   AST_CLK_LOW: assert property (@(posedge clk) disable iff (srst)
      (latch_evt && osc_input_mode_strap == LVL_LOW) |=> !ref_clk_out_en && !osc_in_schmitt)
      else $error("low clock strap gave wrong selection");
   AST_CLK_MID: assert property (@(posedge clk) disable iff (srst)
      (latch_evt && osc_input_mode_strap == LVL_MID) |=> ref_clk_out_en && !osc_in_schmitt)
      else $error("middle clock strap gave wrong selection");
   AST_CLK_HIGH: assert property (@(posedge clk) disable iff (srst)
      (latch_evt && osc_input_mode_strap == LVL_HIGH) |=> ref_clk_out_en && osc_in_schmitt)
      else $error("high clock strap gave wrong selection");
   AST_IRQ_OD: assert property (@(posedge clk) disable iff (srst)
      ($past(irq_od) && irq_oe) |-> !irq_out)
      else $error("open-drain interrupt drove high");
   AST_WAKE_SET: assert property (@(posedge clk) disable iff (srst)
      (wake_en && wake_detect && !wake_clr) |=> wake_pend_r
      ##1 (wake_pend_r || $past(wake_clr) || !$past(wake_en)))
      else $error("wake event not registered");
   AST_WAKE_OFF: assert property (@(posedge clk) disable iff (srst)
      !wake_en |=> wake_event_oe == 3'h0 && wake_event_out == 3'h0)
      else $error("wake output active while disabled");
   AST_ERR_FORCED: assert property (@(posedge clk) disable iff (srst)
      err_force |=> error_indicator_pin == $past(err_led_req) && error_indicator_oe)
      else $error("error function not forced on load failure");

endmodule // reset_strap_wake_pins

// ### verif/board_reset_model.sv
// board side of the active-low reset pin: pull-up plus an external reset source
`timescale 1ns/10ps
module board_reset_model (
   input  wire logic rst_pin_out,
   input  wire logic rst_pin_oe,
   input  wire logic hold_low,
   output logic      rst_pin_n_in
);
   // the pull-up only wins when no party pulls the line down
   assign rst_pin_n_in = !((rst_pin_oe && !rst_pin_out) || hold_low);
endmodule // board_reset_model

// ### verif/reset_strap_wake_pins_test.sv
// self-checking bench for the reset, strap latch, interrupt and wake pin block
`timescale 1ns/10ps
`include "rsw_consts.svh"
module reset_strap_wake_pins_test;
   import rsw_pkg::*;
   typedef struct packed {logic [3:0] strap; logic [1:0] lvl; logic ref_en; logic sch;} row_t;
   logic        clk, srst, avs_read, avs_write, rst_pin_n_in, net_reset_cmd, wake_detect;
   logic        eeprom_load_fail, err_led_req, irq_src, hold_low, rst_pin_out, rst_pin_oe;
   logic        avs_waitrequest, core_reset, straps_valid, ref_clk_out_en, osc_in_schmitt;
   logic        irq_out, irq_oe, error_indicator_pin, error_indicator_oe;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  strap_in, straps_latched;
   logic [1:0]  osc_input_mode_strap;
   logic [2:0]  wake_event_out, wake_event_oe;
   int          fail_count, num_checks;
   // the 10 code is the comparator glitch case: enabled output, no schmitt
   row_t rows [4] = '{'{4'h5, 2'b00, 1'b0, 1'b0}, '{4'ha, 2'b01, 1'b1, 1'b0},
                      '{4'hf, 2'b11, 1'b1, 1'b1}, '{4'h3, 2'b10, 1'b1, 1'b0}};

   reset_strap_wake_pins #(.POR_CYCLES(4), .CMD_RST_CYCLES(3)) dut_u (
      .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rst_pin_n_in(rst_pin_n_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
      .net_reset_cmd(net_reset_cmd), .strap_in(strap_in),
      .osc_input_mode_strap(osc_input_mode_strap), .wake_detect(wake_detect),
      .eeprom_load_fail(eeprom_load_fail), .err_led_req(err_led_req), .irq_src(irq_src),
      .core_reset(core_reset), .straps_latched(straps_latched), .straps_valid(straps_valid),
      .ref_clk_out_en(ref_clk_out_en), .osc_in_schmitt(osc_in_schmitt), .irq_out(irq_out),
      .irq_oe(irq_oe), .error_indicator_pin(error_indicator_pin),
      .error_indicator_oe(error_indicator_oe), .wake_event_out(wake_event_out),
      .wake_event_oe(wake_event_oe));

   board_reset_model brd_u (.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
      .hold_low(hold_low), .rst_pin_n_in(rst_pin_n_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic complete_run();
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one avalon access; the request stands until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 20) begin
         fail_count++;
         complete_run();
      end
   endtask

   task automatic wait_rel();
      int n;
      for (n = 0; n < 400; n++) begin
         @(posedge clk);
         if (rst_pin_oe === 1'b0) break;
      end
      if (n == 400) begin
         fail_count++;
         complete_run();
      end
      repeat (2) @(posedge clk);
   endtask

   // k: 0 irq source, 1 wake event, 2 network reset command
   task automatic pulse(input int k);
      @(posedge clk);
      if (k == 0) irq_src <= 1'b1;
      else if (k == 1) wake_detect <= 1'b1;
      else net_reset_cmd <= 1'b1;
      @(posedge clk);
      irq_src <= 1'b0;
      wake_detect <= 1'b0;
      net_reset_cmd <= 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic chk_row(input row_t r);
      chk(straps_latched, r.strap);
      chk(ref_clk_out_en, r.ref_en);
      chk(osc_in_schmitt, r.sch);
      chk(straps_valid, 1'b1);
   endtask

   initial begin
      srst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
      avs_writedata = 32'h0; net_reset_cmd = 1'b0; wake_detect = 1'b0; irq_src = 1'b0;
      eeprom_load_fail = 1'b0; err_led_req = 1'b0; hold_low = 1'b0;
      strap_in = 4'h5; osc_input_mode_strap = 2'b00; fail_count = 0; num_checks = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk(core_reset, 1'b1);
      chk(rst_pin_oe, 1'b1);
      chk(rst_pin_out, 1'b0);
      chk(straps_valid, 1'b0);
      wait_rel();
      chk_row(rows[0]);
      chk(core_reset, 1'b0);
      foreach (rows[i]) begin
         @(posedge clk);
         strap_in <= rows[i].strap;
         osc_input_mode_strap <= rows[i].lvl;
         pulse(2);
         chk(rst_pin_oe, 1'b1);
         chk(core_reset, 1'b1);
         wait_rel();
         chk_row(rows[i]);
         bus(1'b0, `RSW_OFS_STRAP, 32'h0);
         chk(rd, {19'h0, 1'b1, 2'h0, rows[i].lvl, 4'h0, rows[i].strap});
         strap_in <= ~rows[i].strap;
         osc_input_mode_strap <= ~rows[i].lvl;
         repeat (3) @(negedge clk);
         chk(straps_latched, rows[i].strap);
      end
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `RSW_OFS_CTRL, 32'h1);
      repeat (2) @(negedge clk);
      chk(rst_pin_oe, 1'b1);
      wait_rel();
      chk(straps_latched, 4'hc);
      strap_in <= 4'h6;
      hold_low <= 1'b1;
      repeat (3) @(negedge clk);
      chk(core_reset, 1'b1);
      chk(straps_latched, 4'hc);
      @(posedge clk);
      hold_low <= 1'b0;
      repeat (3) @(negedge clk);
      chk(straps_latched, 4'h6);
      chk(core_reset, 1'b0);
      bus(1'b0, `RSW_OFS_STATUS, 32'h0);
      chk(rd, 32'h3);
      bus(1'b1, `RSW_OFS_MASK, 32'h8);
      bus(1'b1, `RSW_OFS_IRQ_CFG, 32'h1);
      pulse(0);
      chk({irq_out, irq_oe}, 2'b11);
      bus(1'b0, `RSW_OFS_STATUS, 32'h0);
      chk(rd, 32'h8);
      repeat (2) @(negedge clk);
      chk({irq_out, irq_oe}, 2'b01);
      // open drain, active low: the pin is only pulled while asserted
      bus(1'b1, `RSW_OFS_IRQ_CFG, 32'h2);
      pulse(0);
      chk({irq_out, irq_oe}, 2'b01);
      bus(1'b0, `RSW_OFS_STATUS, 32'h0);
      bus(1'b1, `RSW_OFS_MASK, 32'h0);
      pulse(0);
      chk(irq_oe, 1'b0);
      bus(1'b1, `RSW_OFS_WAKE_CFG, 32'h12);
      pulse(1);
      chk({wake_event_out, wake_event_oe}, 6'h00);
      bus(1'b1, `RSW_OFS_WAKE_CFG, 32'h13);
      pulse(1);
      chk(wake_event_out, 3'h1);
      chk(wake_event_oe[0], 1'b1);
      bus(1'b1, `RSW_OFS_CTRL, 32'h2);
      repeat (2) @(negedge clk);
      chk(wake_event_out, 3'h0);
      bus(1'b1, `RSW_OFS_WAKE_CFG, 32'h33);
      pulse(1);
      chk(wake_event_out, 3'h4);
      bus(1'b1, `RSW_OFS_CTRL, 32'h2);
      bus(1'b1, `RSW_OFS_WAKE_CFG, 32'h03);
      err_led_req <= 1'b1;
      repeat (3) @(negedge clk);
      chk({error_indicator_pin, error_indicator_oe}, 2'b01);
      @(posedge clk);
      eeprom_load_fail <= 1'b1;
      repeat (3) @(negedge clk);
      chk({error_indicator_pin, error_indicator_oe}, 2'b11);
      @(posedge clk);
      err_led_req <= 1'b0;
      repeat (3) @(negedge clk);
      chk({error_indicator_pin, error_indicator_oe}, 2'b01);
      // second power-up in mid-run: the internal sequence must start over and relatch
      @(posedge clk);
      srst <= 1'b1;
      strap_in <= 4'h9;
      osc_input_mode_strap <= 2'b11;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk(core_reset, 1'b1);
      chk(rst_pin_oe, 1'b1);
      chk(straps_valid, 1'b0);
      wait_rel();
      chk(straps_latched, 4'h9);
      chk({ref_clk_out_en, osc_in_schmitt}, 2'b11);
      bus(1'b0, `RSW_OFS_STATUS, 32'h0);
      chk(rd, 32'h1);
      complete_run();
   end
endmodule // reset_strap_wake_pins_test
